// >>> logic/itrf_pkg.sv
// Constants, register map and carrier types of the I2C target with remote forwarding
// What this block does
// - Strap level picks one of eight seven-bit addresses 0x30 to 0x3D at power-up.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Acknowledge a matching address by pulling data low; release it otherwise.
// - During writes acknowledge every data byte received; a forwarded byte is acknowledged only if the remote answer is not a refusal.
// - Start or repeated start opens, stop closes each transfer.
// - Works at standard, fast and fast-plus speeds up to 1 MHz.
// - Local register access accepted from 2 ms after power-down pin rises.
// - Local register accesses hold the serial clock low for only three clock cycles at each byte.
// - Strapped primary address readable from the register at offset 0x0.
// - Up to four programmable receive-port addresses reach port registers directly.
// - Second host port decodes the same primary and receive-port addresses.
// - Reset control register at 0x01 is written only from the primary port.
// - Bits 7 to 4 of register 0x0C select links the second port reaches.
// - Remote accesses forwarded; clock held low until answer returns on local bus.
// - Port select at 0x4C picks port; its serializer address shows at 0x5B.
// - Forward only when bit 6 of 0x58 is set and address decodes.
// - Relay only the port's serializer alias or its registered remote aliases.
// - Forward-all relays any address except the primary one; immediate-acknowledge acknowledges at once and sends no remote request.
// - Eight virtual/real pairs per port at 0x5D to 0x6C; real address used remotely.
// - Same virtual address on several ports makes a write a broadcast.
package itrf_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int POWERUP_MS = 2;
  localparam int POWERUP_CYC = CLK_HZ / 1000 * POWERUP_MS;
  localparam int NPORT = 4;
  localparam int NPAIR = 8;
  localparam logic [7:0] A_DEV_ADDR = 8'h00;
  localparam logic [7:0] A_RESET_CONTROL = 8'h01;
  localparam logic [7:0] A_LINK_MAP = 8'h0C;
  localparam logic [7:0] A_PORT_SEL = 8'h4C;
  localparam logic [7:0] A_CC_CFG = 8'h58;
  localparam logic [7:0] A_SER_ADDR = 8'h5B;
  localparam logic [7:0] A_SERIALIZER_VIRTUAL_ADDRESS = 8'h5C;
  localparam logic [7:0] A_REAL_BASE = 8'h5D;
  localparam logic [7:0] A_VIRT_BASE = 8'h65;
  localparam logic [7:0] A_PAIR_LAST = 8'h6C;
  localparam logic [7:0] A_PORT_ADDR_BASE = 8'hF8;
  localparam int CFG_PASS = 6;
  localparam int CFG_PASS_ALL = 7;
  localparam int CFG_AUTO_ACK = 5;
  localparam int MAP_LSB = 4;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [6:0] STRAP_ADDR0 = 7'h30;
  localparam logic [6:0] STRAP_ADDR7 = 7'h3D;
  localparam logic [2:0] STRAP_LAST = 3'h7;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WBYTE = 7'h08,
    ST_WACK = 7'h10,
    ST_RBYTE = 7'h20,
    ST_RACK = 7'h40
  } itrf_state_e;

  typedef struct packed {
    logic valid;
    logic [3:0] port_mask;
    logic [6:0] real_addr;
    logic read;
    logic [7:0] data;
  } itrf_cc_req_s;

  typedef struct packed {
    logic valid;
    logic nack;
    logic [7:0] data;
  } itrf_cc_rsp_s;
endpackage

// >>> logic/itrf_i2c_port.sv
// One I2C target port: framing, shifting, acknowledge and clock stretch
`timescale 1ns/1ps
module itrf_i2c_port (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ready_in,
  input wire logic match_in,
  input wire logic stretch_in,
  input wire logic ack_in,
  input wire logic [7:0] rdata_in,
  output logic sda_oe_out,
  output logic scl_oe_out,
  output logic addr_ev_out,
  output logic wbyte_ev_out,
  output logic rbyte_ev_out,
  output logic stop_ev_out,
  output logic [7:0] byte_out,
  output logic read_out
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_q;
    logic sda_q;
    itrf_pkg::itrf_state_e st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rd;
    logic sda_oe;
    logic scl_oe;
    logic addr_ev;
    logic wb_ev;
    logic rb_ev;
    logic stop_ev;
    logic mack;
    logic setup;
  } port_s;
  port_s q_ff;
  port_s nxt_q;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  always_comb begin
    scl = q_ff.scl_s[1];
    sda = q_ff.sda_s[1];
    rise = scl & ~q_ff.scl_q;
    fall = ~scl & q_ff.scl_q;
    start = scl & q_ff.scl_q & q_ff.sda_q & ~sda;
    stop = scl & q_ff.scl_q & ~q_ff.sda_q & sda;
    nxt_q = q_ff;
    nxt_q.scl_s = {q_ff.scl_s[0], scl_in};
    nxt_q.sda_s = {q_ff.sda_s[0], sda_in};
    nxt_q.scl_q = scl;
    nxt_q.sda_q = sda;
    nxt_q.addr_ev = 1'b0;
    nxt_q.wb_ev = 1'b0;
    nxt_q.rb_ev = 1'b0;
    nxt_q.stop_ev = 1'b0;
    if (start) begin
      nxt_q.st = ready_in ? itrf_pkg::ST_ADDR : itrf_pkg::ST_IDLE;
      nxt_q.cnt = 4'h0;
      nxt_q.sda_oe = 1'b0;
      nxt_q.scl_oe = 1'b0;
    end else if (stop) begin
      nxt_q.st = itrf_pkg::ST_IDLE;
      nxt_q.sda_oe = 1'b0;
      nxt_q.scl_oe = 1'b0;
      nxt_q.stop_ev = 1'b1;
    end else begin
      case (q_ff.st)
        itrf_pkg::ST_ADDR, itrf_pkg::ST_WBYTE: begin
          if (rise) begin
            nxt_q.sh = {q_ff.sh[6:0], sda};
            nxt_q.cnt = q_ff.cnt + 4'h1;
          end
          if (fall && q_ff.cnt == 4'h8) begin
            nxt_q.cnt = 4'h0;
            // stretch while the decision is pending
            nxt_q.scl_oe = 1'b1;
            if (q_ff.st == itrf_pkg::ST_ADDR) begin
              nxt_q.rd = q_ff.sh[0];
              nxt_q.addr_ev = 1'b1;
              nxt_q.st = itrf_pkg::ST_AACK;
            end else begin
              nxt_q.wb_ev = 1'b1;
              nxt_q.st = itrf_pkg::ST_WACK;
            end
          end
        end
        itrf_pkg::ST_AACK, itrf_pkg::ST_WACK: begin
          // clock released unless a remote answer is awaited
          if (q_ff.scl_oe && q_ff.setup) begin
            // Data settles a cycle before the clock is let go
            nxt_q.scl_oe = 1'b0;
            nxt_q.setup = 1'b0;
          end else if (q_ff.scl_oe && !stretch_in && !q_ff.addr_ev && !q_ff.wb_ev) begin
            nxt_q.setup = 1'b1;
            nxt_q.sda_oe = (q_ff.st == itrf_pkg::ST_AACK) ? (match_in & ack_in) : ack_in;
            nxt_q.mack = (q_ff.st == itrf_pkg::ST_AACK) ? (match_in & ack_in) : ack_in;
          end else if (!q_ff.scl_oe && fall) begin
            nxt_q.sda_oe = 1'b0;
            if (!q_ff.mack) begin
              nxt_q.st = itrf_pkg::ST_IDLE;
            end else if (q_ff.st == itrf_pkg::ST_AACK && q_ff.rd) begin
              nxt_q.rb_ev = 1'b1;
              nxt_q.scl_oe = 1'b1;
              nxt_q.st = itrf_pkg::ST_RBYTE;
            end else begin
              nxt_q.st = itrf_pkg::ST_WBYTE;
            end
          end
        end
        itrf_pkg::ST_RBYTE: begin
          if (q_ff.scl_oe) begin
            if (q_ff.setup) begin
              nxt_q.scl_oe = 1'b0;
              nxt_q.setup = 1'b0;
            end else if (!stretch_in && !q_ff.rb_ev) begin
              nxt_q.setup = 1'b1;
              nxt_q.sh = {rdata_in[6:0], 1'b0};
              nxt_q.sda_oe = ~rdata_in[7];
              nxt_q.cnt = 4'h1;
            end
          end else if (fall) begin
            if (q_ff.cnt == 4'h8) begin
              nxt_q.sda_oe = 1'b0;
              nxt_q.st = itrf_pkg::ST_RACK;
            end else begin
              nxt_q.sda_oe = ~q_ff.sh[7];
              nxt_q.sh = {q_ff.sh[6:0], 1'b0};
              nxt_q.cnt = q_ff.cnt + 4'h1;
            end
          end
        end
        itrf_pkg::ST_RACK: begin
          // host ack continues, nack ends the read
          if (rise) begin
            nxt_q.mack = ~sda;
          end
          if (fall) begin
            if (q_ff.mack) begin
              nxt_q.rb_ev = 1'b1;
              nxt_q.scl_oe = 1'b1;
              nxt_q.st = itrf_pkg::ST_RBYTE;
            end else begin
              nxt_q.st = itrf_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          nxt_q.st = itrf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_ff <= '{scl_s: 2'h3, sda_s: 2'h3, scl_q: 1'b1, sda_q: 1'b1, st: itrf_pkg::ST_IDLE, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sda_oe_out = q_ff.sda_oe;
  assign scl_oe_out = q_ff.scl_oe;
  assign addr_ev_out = q_ff.addr_ev;
  assign wbyte_ev_out = q_ff.wb_ev;
  assign rbyte_ev_out = q_ff.rb_ev;
  assign stop_ev_out = q_ff.stop_ev;
  assign byte_out = q_ff.sh;
  assign read_out = q_ff.rd;
endmodule

// >>> logic/itrf_top.sv
// Top of the I2C target: two host ports, register file and remote forwarding
`timescale 1ns/1ps
module itrf_top #(
  parameter int POWERUP_CYCLES = itrf_pkg::POWERUP_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] address_strap_pin_in,
  input wire logic [1:0] scl_in,
  input wire logic [1:0] sda_in,
  output logic [1:0] scl_oe_out,
  output logic [1:0] sda_oe_out,
  output itrf_pkg::itrf_cc_req_s cc_req_out,
  input wire logic cc_req_ready_in,
  input itrf_pkg::itrf_cc_rsp_s cc_rsp_in,
  input wire logic [6:0] serializer_real_address_in [itrf_pkg::NPORT],
  output logic [7:0] reset_control_out
);
  localparam int NP = itrf_pkg::NPORT;
  localparam int NV = itrf_pkg::NPAIR;

  typedef struct packed {
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [6:0] dev_addr;
    logic [7:0] reset_control;
    logic [7:0] link_map;
    logic [7:0] port_sel;
    logic [7:0] cc_cfg;
    logic [NP-1:0][7:0] serializer_virtual_address;
    logic [NP-1:0][7:0] port_addr;
    logic [NP-1:0][NV-1:0][7:0] real_a;
    logic [NP-1:0][NV-1:0][7:0] virt_a;
    logic [31:0] pwr_cnt;
    logic ready;
    logic [1:0] hit_local;
    logic [1:0][NP-1:0] hit_port;
    logic [1:0] hit_remote;
    logic [1:0][NP-1:0] fwd_mask;
    logic [1:0][6:0] fwd_real;
    logic [1:0] idx_set;
    logic [1:0][7:0] idx;
    logic [1:0] stretch;
    logic [1:0] ack;
    logic [1:0][7:0] rdata;
    logic busy;
    logic owner;
    itrf_pkg::itrf_cc_req_s req;
    itrf_pkg::itrf_cc_req_s [1:0] pend;
  } top_s;
  top_s q_ff;
  top_s nxt_q;

  logic [1:0] addr_ev;
  logic [1:0] wb_ev;
  logic [1:0] rb_ev;
  logic [1:0] stop_ev;
  logic [1:0] rd;
  logic [1:0][7:0] byte_v;
  logic [1:0] match;

  function automatic logic [7:0] reg_read(input top_s s, input logic [7:0] a, input logic [NP-1:0] pm);
    logic [7:0] v;
    int p;
    v = 8'h00;
    p = 0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (pm[i]) begin
        p = i;
      end
    end
    if (a == itrf_pkg::A_DEV_ADDR) begin
      v = {s.dev_addr, 1'b0};
    end else if (a == itrf_pkg::A_RESET_CONTROL) begin
      v = s.reset_control;
    end else if (a == itrf_pkg::A_LINK_MAP) begin
      v = s.link_map;
    end else if (a == itrf_pkg::A_PORT_SEL) begin
      v = s.port_sel;
    end else if (a == itrf_pkg::A_CC_CFG) begin
      v = s.cc_cfg;
    end else if (a == itrf_pkg::A_SER_ADDR) begin
      v = {serializer_real_address_in[p], 1'b0};
    end else if (a == itrf_pkg::A_SERIALIZER_VIRTUAL_ADDRESS) begin
      v = s.serializer_virtual_address[p];
    end else if (a >= itrf_pkg::A_REAL_BASE && a < itrf_pkg::A_VIRT_BASE) begin
      v = s.real_a[p][3'(a - itrf_pkg::A_REAL_BASE)];
    end else if (a >= itrf_pkg::A_VIRT_BASE && a <= itrf_pkg::A_PAIR_LAST) begin
      v = s.virt_a[p][3'(a - itrf_pkg::A_VIRT_BASE)];
    end else if (a >= itrf_pkg::A_PORT_ADDR_BASE && a < itrf_pkg::A_PORT_ADDR_BASE + 8'(NP)) begin
      v = s.port_addr[2'(a - itrf_pkg::A_PORT_ADDR_BASE)];
    end
    return v;
  endfunction

  // identical port instances share one decode
  for (genvar g = 0; g < 2; g++) begin : g_port
    itrf_i2c_port u_port (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .scl_in(scl_in[g]),
      .sda_in(sda_in[g]),
      .ready_in(q_ff.ready),
      .match_in(match[g]),
      .stretch_in(q_ff.stretch[g]),
      .ack_in(q_ff.ack[g]),
      .rdata_in(q_ff.rdata[g]),
      .sda_oe_out(sda_oe_out[g]),
      .scl_oe_out(scl_oe_out[g]),
      .addr_ev_out(addr_ev[g]),
      .wbyte_ev_out(wb_ev[g]),
      .rbyte_ev_out(rb_ev[g]),
      .stop_ev_out(stop_ev[g]),
      .byte_out(byte_v[g]),
      .read_out(rd[g])
    );
  end

  always_comb begin
    logic [6:0] a7;
    logic [NP-1:0] pm;
    logic [NP-1:0] fm;
    logic [6:0] fr;
    logic [NP-1:0] allow;
    a7 = 7'h00;
    pm = '0;
    fm = '0;
    fr = 7'h00;
    allow = '0;
    nxt_q = q_ff;
    nxt_q.strap_s1 = address_strap_pin_in;
    nxt_q.strap_s2 = q_ff.strap_s1;
    // accept local access after power-up delay
    if (!q_ff.ready) begin
      nxt_q.pwr_cnt = q_ff.pwr_cnt + 32'h1;
      nxt_q.dev_addr = (q_ff.strap_s2 == itrf_pkg::STRAP_LAST) ? itrf_pkg::STRAP_ADDR7 :
                       itrf_pkg::STRAP_ADDR0 + {3'h0, q_ff.strap_s2, 1'b0};
      if (q_ff.pwr_cnt >= 32'(POWERUP_CYCLES - 1)) begin
        nxt_q.ready = 1'b1;
      end
    end
    for (int g = 0; g < 2; g++) begin
      // link map limits the second port
      allow = (g == 1) ? q_ff.link_map[itrf_pkg::MAP_LSB +: NP] : {NP{1'b1}};
      if (stop_ev[g]) begin
        nxt_q.stretch[g] = 1'b0;
      end
      if (addr_ev[g]) begin
        a7 = byte_v[g][7:1];
        nxt_q.idx_set[g] = 1'b0;
        nxt_q.hit_local[g] = (a7 == q_ff.dev_addr);
        fm = '0;
        fr = 7'h00;
        for (int p = 0; p < NP; p++) begin
          nxt_q.hit_port[g][p] = q_ff.port_addr[p][7:1] == a7 && q_ff.port_addr[p][7:1] != 7'h00;
          if (allow[p]) begin
            if (q_ff.serializer_virtual_address[p][7:1] == a7 && a7 != 7'h00) begin
              fm[p] = 1'b1;
              fr = serializer_real_address_in[p];
            end
            for (int v = 0; v < NV; v++) begin
              if (q_ff.virt_a[p][v][7:1] == a7 && a7 != 7'h00) begin
                // each matching port joins the broadcast
                fm[p] = 1'b1;
                fr = q_ff.real_a[p][v][7:1];
              end
            end
          end
        end
        if (q_ff.cc_cfg[itrf_pkg::CFG_PASS_ALL] && fm == '0 && a7 != q_ff.dev_addr) begin
          fm = (q_ff.port_sel[NP-1:0] & allow);
          fr = a7;
        end
        nxt_q.hit_remote[g] = q_ff.cc_cfg[itrf_pkg::CFG_PASS] && fm != '0;
        nxt_q.fwd_mask[g] = fm;
        nxt_q.fwd_real[g] = fr;
        nxt_q.ack[g] = 1'b1;
        if (q_ff.cc_cfg[itrf_pkg::CFG_PASS] && fm != '0 && !q_ff.cc_cfg[itrf_pkg::CFG_AUTO_ACK]) begin
          // address phase goes to the remote side
          nxt_q.stretch[g] = 1'b1;
          nxt_q.pend[g] = '{valid: 1'b0, port_mask: fm, real_addr: fr, read: byte_v[g][0], data: 8'h00};
        end
      end
      // Data phases only; the address phase raised its own request above
      if (q_ff.hit_remote[g] && (wb_ev[g] || rb_ev[g]) && !q_ff.cc_cfg[itrf_pkg::CFG_AUTO_ACK]) begin
        nxt_q.stretch[g] = 1'b1;
        nxt_q.pend[g] = '{valid: 1'b0, port_mask: q_ff.fwd_mask[g], real_addr: q_ff.fwd_real[g],
                      read: rb_ev[g], data: byte_v[g]};
      end
      if (!q_ff.hit_remote[g] && wb_ev[g] && q_ff.hit_local[g] | (q_ff.hit_port[g] != '0)) begin
        nxt_q.ack[g] = 1'b1;
        if (!q_ff.idx_set[g]) begin
          nxt_q.idx_set[g] = 1'b1;
          nxt_q.idx[g] = byte_v[g];
        end else begin
          nxt_q.idx[g] = q_ff.idx[g] + 8'h01;
          pm = q_ff.hit_port[g] != '0 ? q_ff.hit_port[g] : q_ff.port_sel[NP-1:0];
          // reset control only from the primary port
          if (q_ff.idx[g] == itrf_pkg::A_RESET_CONTROL && g == 0) begin
            nxt_q.reset_control = byte_v[g];
          end else if (q_ff.idx[g] == itrf_pkg::A_LINK_MAP) begin
            nxt_q.link_map = byte_v[g];
          end else if (q_ff.idx[g] == itrf_pkg::A_PORT_SEL) begin
            nxt_q.port_sel = byte_v[g];
          end else if (q_ff.idx[g] == itrf_pkg::A_CC_CFG) begin
            nxt_q.cc_cfg = byte_v[g];
          end
          for (int p = 0; p < NP; p++) begin
            if (pm[p]) begin
              if (q_ff.idx[g] == itrf_pkg::A_SERIALIZER_VIRTUAL_ADDRESS) begin
                nxt_q.serializer_virtual_address[p] = byte_v[g];
              end else if (q_ff.idx[g] >= itrf_pkg::A_REAL_BASE && q_ff.idx[g] < itrf_pkg::A_VIRT_BASE) begin
                nxt_q.real_a[p][3'(q_ff.idx[g] - itrf_pkg::A_REAL_BASE)] = byte_v[g];
              end else if (q_ff.idx[g] >= itrf_pkg::A_VIRT_BASE && q_ff.idx[g] <= itrf_pkg::A_PAIR_LAST) begin
                nxt_q.virt_a[p][3'(q_ff.idx[g] - itrf_pkg::A_VIRT_BASE)] = byte_v[g];
              end
            end
            if (q_ff.idx[g] == itrf_pkg::A_PORT_ADDR_BASE + 8'(p)) begin
              nxt_q.port_addr[p] = byte_v[g];
            end
          end
        end
      end
      if (!q_ff.hit_remote[g] && rb_ev[g]) begin
        pm = q_ff.hit_port[g] != '0 ? q_ff.hit_port[g] : q_ff.port_sel[NP-1:0];
        nxt_q.rdata[g] = reg_read(q_ff, q_ff.idx[g], pm);
        nxt_q.idx[g] = q_ff.idx[g] + 8'h01;
      end
    end
    // one request at a time on the channel
    if (!q_ff.busy) begin
      for (int g = 1; g >= 0; g--) begin
        if (q_ff.stretch[g]) begin
          nxt_q.owner = 1'(g);
          nxt_q.req = q_ff.pend[g];
        end
      end
      if (q_ff.stretch != 2'b00) begin
        nxt_q.req.valid = 1'b1;
        nxt_q.busy = 1'b1;
      end
    end else if (q_ff.req.valid) begin
      if (cc_req_ready_in) begin
        nxt_q.req.valid = 1'b0;
      end
    end else if (cc_rsp_in.valid) begin
      // host waited while the clock was held
      nxt_q.busy = 1'b0;
      nxt_q.stretch[q_ff.owner] = 1'b0;
      nxt_q.ack[q_ff.owner] = ~cc_rsp_in.nack;
      nxt_q.rdata[q_ff.owner] = cc_rsp_in.data;
    end
  end

  assign match[0] = q_ff.hit_local[0] | (q_ff.hit_port[0] != '0) | q_ff.hit_remote[0];
  assign match[1] = q_ff.hit_local[1] | (q_ff.hit_port[1] != '0) | q_ff.hit_remote[1];

  // sampling at 40 MHz covers 1 MHz serial clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign cc_req_out = q_ff.req;
  assign reset_control_out = q_ff.reset_control;
endmodule

// >>> tb/itrf_top_assertions.sv
// Port-level checker of the forwarding I2C target
`timescale 1ns/1ps
module itrf_top_assertions (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] scl_in,
  input wire logic [1:0] scl_oe_out,
  input wire logic [1:0] sda_oe_out,
  input itrf_pkg::itrf_cc_req_s cc_req_out,
  input wire logic cc_req_ready_in,
  input itrf_pkg::itrf_cc_rsp_s cc_rsp_in
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ****
  // Stretch without a pending request
  // ****
  logic saw_ff;
  logic [3:0] cnt_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      saw_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end else begin
      saw_ff <= scl_oe_out[0] & (saw_ff | cc_req_out.valid);
      cnt_ff <= (scl_oe_out[0] & ~saw_ff & ~cc_req_out.valid) ? cnt_ff + 4'h1 : 4'h0;
    end
  end
  property p_req_hold;
    cc_req_out.valid && !cc_req_ready_in |=> cc_req_out.valid && $stable(cc_req_out);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ready");
  property p_local;
    cnt_ff < 4'h8;
  endproperty
  a_local: assert property (p_local) else $error("local access stretched the clock");
  property p_stretch_low;
    $rose(scl_oe_out[0]) |-> !scl_in[0];
  endproperty
  a_stretch_low: assert property (p_stretch_low) else $error("stretch began with clock high");
  property p_sda0;
    $changed(sda_oe_out[0]) |-> !scl_in[0];
  endproperty
  a_sda0: assert property (p_sda0) else $error("port 0 data moved while clock high");
  property p_sda1;
    $changed(sda_oe_out[1]) |-> !scl_in[1];
  endproperty
  a_sda1: assert property (p_sda1) else $error("port 1 data moved while clock high");
  property p_release;
    cc_rsp_in.valid && scl_oe_out[0] |-> ##[1:8] !scl_oe_out[0];
  endproperty
  a_release: assert property (p_release) else $error("clock not released after answer");
  property p_req_stretch;
    $rose(cc_req_out.valid) |-> ##[0:4] (scl_oe_out != 2'b00);
  endproperty
  a_req_stretch: assert property (p_req_stretch) else $error("request without stretch");
  property p_nack;
    cc_rsp_in.valid && cc_rsp_in.nack && scl_oe_out[0] |=> !sda_oe_out[0] [*8];
  endproperty
  a_nack: assert property (p_nack) else $error("remote refusal was acknowledged");
  property p_mask;
    cc_req_out.valid |-> cc_req_out.port_mask != 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("request with no port");
  c_req: cover property (cc_req_out.valid && cc_req_ready_in);
  c_nack: cover property (cc_rsp_in.valid && cc_rsp_in.nack);
  c_bcast: cover property (cc_req_out.valid && cc_req_out.port_mask == 4'hF);
endmodule
bind itrf_top itrf_top_assertions u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
  .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out), .cc_req_out(cc_req_out),
  .cc_req_ready_in(cc_req_ready_in), .cc_rsp_in(cc_rsp_in));

// >>> tb/itrf_cc_model.sv
// Far end of the control channel: takes requests, answers after a delay
`timescale 1ns/1ps
module itrf_cc_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input itrf_pkg::itrf_cc_req_s req_in,
  input wire logic nack_in,
  input wire logic [3:0] delay_in,
  input wire logic [7:0] rdata_in,
  output logic ready_out,
  output itrf_pkg::itrf_cc_rsp_s rsp_out,
  output itrf_pkg::itrf_cc_req_s last_out
);
  logic busy;
  logic [3:0] cnt;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ready_out <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
      rsp_out <= '0;
      last_out <= '0;
    end else begin
      ready_out <= 1'b0;
      rsp_out.valid <= 1'b0;
      // Idle answer data flips so a stale byte is never mistaken
      if (!rsp_out.valid) rsp_out.data <= ~rsp_out.data;
      if (req_in.valid && !ready_out && !busy) begin
        ready_out <= 1'b1;
        last_out <= req_in;
        busy <= 1'b1;
        cnt <= delay_in;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h0) begin
          busy <= 1'b0;
          rsp_out.valid <= 1'b1;
          rsp_out.nack <= nack_in;
          rsp_out.data <= rdata_in;
        end
      end
    end
  end
endmodule

// >>> tb/itrf_top_tb.sv
// Self-checking bench: host I2C on both ports, model on the channel
`timescale 1ns/1ps
module itrf_top_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [1:0] hs = 2'h0;
  logic [1:0] hd = 2'h0;
  wire [1:0] scl_w;
  wire [1:0] sda_w;
  logic [1:0] scl_oe;
  logic [1:0] sda_oe;
  itrf_pkg::itrf_cc_req_s req;
  itrf_pkg::itrf_cc_req_s last;
  itrf_pkg::itrf_cc_rsp_s rsp;
  logic rdy;
  logic nack = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [7:0] rdat = 8'h00;
  logic [7:0] rc;
  logic [6:0] ser [itrf_pkg::NPORT] = '{7'h11, 7'h22, 7'h33, 7'h44};
  logic [6:0] dv;
  logic [23:0] exq[$];
  logic [23:0] obs;
  string nq[$];
  int errors = 0;
  int cmp_count = 0;
  event ev;
  // Open-drain wires with pull-ups
  assign scl_w = ~(hs | scl_oe);
  assign sda_w = ~(hd | sda_oe);
  always #12.5 clk_in = ~clk_in;
  itrf_top #(.POWERUP_CYCLES(20)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .address_strap_pin_in(strap),
    .scl_in(scl_w), .sda_in(sda_w), .scl_oe_out(scl_oe), .sda_oe_out(sda_oe), .cc_req_out(req),
    .cc_req_ready_in(rdy), .cc_rsp_in(rsp), .serializer_real_address_in(ser), .reset_control_out(rc));
  itrf_cc_model u_cc (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .nack_in(nack),
    .delay_in(dly), .rdata_in(rdat), .ready_out(rdy), .rsp_out(rsp), .last_out(last));
  // ****
  // Host tasks
  // ****
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic put(input string s, input logic [23:0] v);
    nq.push_back(s);
    exq.push_back(v);
  endtask
  task automatic show(input logic [23:0] v);
    obs = v;
    -> ev;
    #1;
  endtask
  task automatic check(input string s, input logic [23:0] seen, input logic [23:0] e);
    cmp_count++;
    if (seen !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", s, e, seen);
    end
  endtask
  always @(ev) check(nq.pop_front(), obs, exq.pop_front());
  task automatic bitx(input int p, input logic b, output logic r);
    @(posedge clk_in) hd[p] <= !b;
    wt(20);
    hs[p] <= 1'b0;
    for (int i = 0; i < 4000 && scl_w[p] !== 1'b1; i++) wt(1);
    wt(10);
    r = sda_w[p];
    wt(10);
    hs[p] <= 1'b1;
  endtask
  task automatic tx(input int p, input logic [7:0] b, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(p, b[i], r);
    bitx(p, 1'b1, r);
    a = !r;
  endtask
  task automatic rx(input int p, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(p, 1'b1, d[i]);
    bitx(p, 1'b1, r);
  endtask
  task automatic sta(input int p);
    @(posedge clk_in) hd[p] <= 1'b0;
    wt(10);
    hs[p] <= 1'b0;
    wt(20);
    hd[p] <= 1'b1;
    wt(20);
    hs[p] <= 1'b1;
  endtask
  task automatic sto(input int p);
    @(posedge clk_in) hd[p] <= 1'b1;
    wt(10);
    hs[p] <= 1'b0;
    wt(20);
    hd[p] <= 1'b0;
    wt(20);
  endtask
  task automatic wr(input int p, input logic [6:0] a, input logic [7:0] i, input logic [7:0] d);
    logic [2:0] k;
    sta(p);
    tx(p, {a, 1'b0}, k[2]);
    tx(p, i, k[1]);
    tx(p, d, k[0]);
    sto(p);
    show({21'h0, k});
  endtask
  task automatic rd(input int p, input logic [6:0] a, input logic [7:0] i);
    logic [2:0] k;
    logic [7:0] d;
    sta(p);
    tx(p, {a, 1'b0}, k[2]);
    tx(p, i, k[1]);
    sta(p);
    tx(p, {a, 1'b1}, k[0]);
    rx(p, d);
    sto(p);
    show({13'h0, k, d});
  endtask
  task automatic cfg(input logic [7:0] i, input logic [7:0] d);
    put("cfg", 24'h7);
    wr(0, dv, i, d);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    wt(90000);
    errors++;
    end_of_test();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    logic [7:0] v;
    void'($urandom(3656));
    @(posedge clk_in) strap <= 3'($urandom_range(6, 0));
    wt(6);
    rst_n_in <= 1'b1;
    wt(40);
    dv = 7'h30 + 7'({strap, 1'b0});
    put("rst", {16'h0, itrf_pkg::RST_VAL});
    show({16'h0, rc});
    for (int p = 0; p < 2; p++) begin
      put("id", {13'h0, 3'h7, dv, 1'b0});
      rd(p, dv, itrf_pkg::A_DEV_ADDR);
    end
    put("nomatch", 24'h0);
    wr(0, dv + 7'h1, 8'h00, 8'h00);
    v = 8'($urandom);
    put("ack1", 24'h7);
    wr(1, dv, itrf_pkg::A_RESET_CONTROL, v);
    put("rc1", {16'h0, itrf_pkg::RST_VAL});
    show({16'h0, rc});
    cfg(itrf_pkg::A_RESET_CONTROL, v);
    put("rc0", {16'h0, v});
    show({16'h0, rc});
    cfg(itrf_pkg::A_PORT_SEL, 8'h0F);
    cfg(itrf_pkg::A_REAL_BASE, 8'h60);
    cfg(itrf_pkg::A_VIRT_BASE, 8'h90);
    cfg(itrf_pkg::A_CC_CFG, 8'h00);
    put("off", 24'h0);
    wr(0, 7'h48, 8'h00, 8'h00);
    cfg(itrf_pkg::A_CC_CFG, 8'h40);
    cfg(itrf_pkg::A_LINK_MAP, 8'h00);
    put("map", 24'h0);
    wr(1, 7'h48, 8'h00, 8'h00);
    cfg(itrf_pkg::A_LINK_MAP, 8'hF0);
    for (int n = 0; n < 3; n++) begin
      v = 8'($urandom);
      @(posedge clk_in) dly <= 4'($urandom);
      put("fwd", 24'h7);
      wr(n % 2, 7'h48, v, v);
      put("req", {4'h1, 4'hF, 7'h30, 1'b0, v});
      show(24'(last));
    end
    @(posedge clk_in) nack <= 1'b1;
    put("rnak", 24'h0);
    wr(0, 7'h48, 8'h00, 8'h00);
    @(posedge clk_in) nack <= 1'b0;
    put("miss", 24'h0);
    wr(0, 7'h49, 8'h00, 8'h00);
    cfg(itrf_pkg::A_PORT_ADDR_BASE, 8'h50);
    put("rxid", {13'h0, 3'h7, 8'h0F});
    rd(0, 7'h28, itrf_pkg::A_PORT_SEL);
    v = 8'($urandom);
    @(posedge clk_in) rdat <= v;
    put("rread", {13'h0, 3'h7, v});
    rd(0, 7'h48, 8'h00);
    cfg(itrf_pkg::A_CC_CFG, 8'hC0);
    put("all", 24'h7);
    wr(0, 7'h4A, 8'h00, 8'h00);
    put("allreq", {4'h1, 4'hF, 7'h4A, 1'b0, 8'h00});
    show(24'(last));
    cfg(itrf_pkg::A_PORT_SEL, 8'h02);
    put("ser", {13'h0, 3'h7, ser[1], 1'b0});
    rd(0, dv, itrf_pkg::A_SER_ADDR);
    end_of_test();
  end
endmodule
